/* rtl/ep2_pkg.sv */
package ep2_pkg;

  localparam logic [7:0]  EP2_CSR_OFFSET  = 8'h28;
  localparam logic [31:0] EP2_CSR_RESET   = 32'h0000_2001;

  localparam int BIT_IN_CLEAR_TOGGLE  = 30;
  localparam int BIT_IN_STALL_SENT    = 29;
  localparam int BIT_IN_SEND_STALL    = 28;
  localparam int BIT_IN_FIFO_FLUSH    = 27;
  localparam int BIT_IN_UNDERRUN      = 26;
  localparam int BIT_IN_OCC_HI        = 25;
  localparam int BIT_IN_PACKET_READY  = 24;
  localparam int BIT_OUT_CLEAR_TOGGLE = 23;
  localparam int BIT_OUT_STALL_SENT   = 22;
  localparam int BIT_IN_ISO_MODE      = 14;
  localparam int BIT_DIRECTION        = 13;
  localparam int BIT_MAX_PACKET_LO    = 0;
  localparam int MAX_PACKET_WIDTH     = 4;

  localparam logic       RESET_DIRECTION  = 1'b1;
  localparam logic [3:0] RESET_MAX_PACKET = 4'h1;
  localparam int         MAX_PACKET_STEP  = 8;

  localparam logic [1:0] OCC_NONE = 2'h0;
  localparam logic [1:0] OCC_ONE  = 2'h2;
  localparam logic [1:0] OCC_FULL = 2'h3;

  localparam int FIFO_BYTES_DEFAULT = 128;

endpackage : ep2_pkg

/* rtl/in_fifo_tracker.sv */
module in_fifo_tracker #(
  parameter int FIFO_BYTES = ep2_pkg::FIFO_BYTES_DEFAULT
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       push,
  input  wire logic       pop,
  input  wire logic [7:0] max_bytes,
  output logic      [1:0] occupancy
);

  logic [1:0] count_q;
  logic [1:0] count_d;
  logic       big;

  assign big = 32'(max_bytes) > (FIFO_BYTES / 2);

  always_comb begin
    count_d = count_q;
    if (push && !pop && count_q != 2'h2) begin
      count_d = count_q + 2'h1;
    end else if (pop && !push && count_q != 2'h0) begin
      count_d = count_q - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count_q <= 2'h0;
    end else begin
      count_q <= count_d;
    end
  end

  // Occupancy code
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      occupancy <= ep2_pkg::OCC_NONE;
    end else if (count_d == 2'h0) begin
      occupancy <= ep2_pkg::OCC_NONE;
    end else if (count_d == 2'h2 || big) begin
      occupancy <= ep2_pkg::OCC_FULL;
    end else begin
      occupancy <= ep2_pkg::OCC_ONE;
    end
  end

endmodule : in_fifo_tracker

/* rtl/usb_endpoint_in_control_status.sv */
// Overview of operation
// - Control/status register at byte offset 0x28, 32 bits, reset 0x0000_2001.
// - IN stall-sent set on STALL answer to IN token; read clears it.
// - IN send-stall set by CPU makes IN tokens get STALL until cleared.
// - CPU attempts to set packet-ready are ignored while send-stall set.
// - IN flush discards FIFO packet, self-clears flush bit, pulses interrupt.
// - Flush waits while a token transaction is still in progress.
// - Flush discards only the oldest packet and clears its packet-ready.
// - Iso IN token with packet-ready clear sets underrun; read clears it.
// - Underrun sends zero-length packet and flushes the next loaded packet.
// - Occupancy in bits 25:24: 10 one packet, 11 two or one large; one packet with packet-ready set reads 11.
// - CPU sets packet-ready; cleared when host got packet, with interrupt.
// - FIFO writes are blocked while packet-ready is set.
// - OUT clear-toggle written 1 in OUT direction resets OUT toggle to DATA0.
// - OUT stall-sent set when OUT token ends in STALL; read clears it.
// - OUT data longer than maximum packet size is answered with STALL.
// - IN flags act only in IN direction, OUT flags in OUT; underrun iso.
// - Direction bit 13: 0 OUT, 1 IN, IN after reset.
// - Bit 14 selects isochronous (1) or bulk (0) IN transfers.
// - Four-bit max packet field in 8-byte steps, 1000 is 64 bytes.
//
// The Avalon-MM slave port was chosen for this implementation.
module usb_endpoint_in_control_status #(
  parameter int FIFO_BYTES = ep2_pkg::FIFO_BYTES_DEFAULT
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RESET_N,
  input  wire logic [7:0]  ADDRESS,
  input  wire logic        READ,
  input  wire logic        WRITE,
  input  wire logic [31:0] WRITEDATA,
  input  wire logic [3:0]  BYTEENABLE,
  output logic      [31:0] READDATA,
  output logic             WAITREQUEST,
  input  wire logic        IN_TOKEN,
  input  wire logic        IN_XFER_DONE,
  input  wire logic        TOKEN_BUSY,
  input  wire logic        OUT_DATA_END,
  input  wire logic [7:0]  OUT_RX_BYTES,
  output logic             IN_SEND_DATA,
  output logic             IN_SEND_NAK,
  output logic             IN_SEND_STALL,
  output logic             IN_SEND_ZLP,
  output logic             OUT_SEND_STALL,
  output logic             OUT_SEND_ACK,
  output logic             FIFO_FLUSH_ONE,
  output logic             FIFO_WR_BLOCK,
  output logic             IN_TOGGLE,
  output logic             OUT_TOGGLE,
  output logic             CPU_IRQ
);

  default clocking @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESET_N);

  function automatic logic wbit(input logic [31:0] d, input logic [3:0] be,
                                input int pos);
    wbit = be[pos / 8] & d[pos];
  endfunction : wbit

  function automatic logic [7:0] max_bytes(input logic [3:0] code);
    max_bytes = (code == 4'h0) ? 8'(ep2_pkg::MAX_PACKET_STEP)
                               : 8'(code * ep2_pkg::MAX_PACKET_STEP);
  endfunction : max_bytes

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave

  logic        waitreq_q;
  logic        hit;
  logic        wr_go;
  logic        rd_go;
  logic [31:0] clr_mask;
  logic [31:0] reg_value;

  logic       direction_q;
  logic       iso_q;
  logic [3:0] max_packet_q;
  logic       send_stall_q;
  logic       flush_q;
  logic       ready_q;
  logic       in_stall_sent_q;
  logic       underrun_q;
  logic       out_stall_sent_q;
  logic       flush_next_q;
  logic [1:0] occupancy;

  assign hit   = ADDRESS == ep2_pkg::EP2_CSR_OFFSET;
  assign wr_go = WRITE && !waitreq_q && hit;
  assign rd_go = READ && !waitreq_q && hit;
  assign clr_mask = rd_go ? READDATA : 32'h0000_0000;

  always_comb begin
    reg_value = 32'h0000_0000;
    reg_value[ep2_pkg::BIT_IN_STALL_SENT]   = in_stall_sent_q;
    reg_value[ep2_pkg::BIT_IN_SEND_STALL]   = send_stall_q;
    reg_value[ep2_pkg::BIT_IN_FIFO_FLUSH]   = flush_q;
    reg_value[ep2_pkg::BIT_IN_UNDERRUN]     = underrun_q;
    reg_value[ep2_pkg::BIT_IN_OCC_HI]       = occupancy[1];
    reg_value[ep2_pkg::BIT_IN_PACKET_READY] = ready_q | occupancy[0];
    reg_value[ep2_pkg::BIT_OUT_STALL_SENT]  = out_stall_sent_q;
    reg_value[ep2_pkg::BIT_IN_ISO_MODE]     = iso_q;
    reg_value[ep2_pkg::BIT_DIRECTION]       = direction_q;
    reg_value[ep2_pkg::BIT_MAX_PACKET_LO +: ep2_pkg::MAX_PACKET_WIDTH] =
      max_packet_q;
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      waitreq_q <= 1'b1;
    end else begin
      waitreq_q <= !((READ || WRITE) && waitreq_q);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      READDATA <= 32'h0000_0000;
    end else if (READ && waitreq_q) begin
      READDATA <= hit ? reg_value : 32'h0000_0000;
    end
  end

  assign WAITREQUEST = waitreq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration fields

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      direction_q  <= ep2_pkg::RESET_DIRECTION;
      iso_q        <= ep2_pkg::EP2_CSR_RESET[ep2_pkg::BIT_IN_ISO_MODE];
      max_packet_q <= ep2_pkg::RESET_MAX_PACKET;
    end else if (wr_go) begin
      if (BYTEENABLE[1]) begin
        direction_q <= WRITEDATA[ep2_pkg::BIT_DIRECTION];
        iso_q       <= WRITEDATA[ep2_pkg::BIT_IN_ISO_MODE];
      end
      if (BYTEENABLE[0]) begin
        max_packet_q <= WRITEDATA[ep2_pkg::BIT_MAX_PACKET_LO +:
                                  ep2_pkg::MAX_PACKET_WIDTH];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // IN side events

  logic in_tok;
  logic stall_ev;
  logic under_ev;
  logic data_ev;
  logic nak_ev;
  logic sent_ev;
  logic cpu_set_ready;
  logic discard_load;
  logic flush_do;
  logic out_end;
  logic out_stall_ev;

  assign in_tok   = IN_TOKEN && direction_q;
  assign stall_ev = in_tok && send_stall_q;
  assign under_ev = in_tok && !send_stall_q && iso_q && !ready_q;
  assign data_ev  = in_tok && !send_stall_q && ready_q;
  assign nak_ev   = in_tok && !send_stall_q && !iso_q && !ready_q;
  assign sent_ev  = IN_XFER_DONE && direction_q && ready_q;
  assign cpu_set_ready = wr_go && direction_q && !send_stall_q && !ready_q &&
    wbit(WRITEDATA, BYTEENABLE, ep2_pkg::BIT_IN_PACKET_READY);
  assign discard_load = cpu_set_ready && flush_next_q;
  assign flush_do = flush_q && !TOKEN_BUSY && direction_q;

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      send_stall_q <= 1'b0;
    end else if (wr_go && BYTEENABLE[3] && direction_q) begin
      send_stall_q <= WRITEDATA[ep2_pkg::BIT_IN_SEND_STALL];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      flush_q <= 1'b0;
    end else if (flush_do) begin
      flush_q <= 1'b0;
    end else if (wr_go && direction_q &&
                 wbit(WRITEDATA, BYTEENABLE, ep2_pkg::BIT_IN_FIFO_FLUSH)) begin
      flush_q <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      ready_q <= 1'b0;
    end else if (stall_ev || sent_ev || flush_do) begin
      ready_q <= 1'b0;
    end else if (cpu_set_ready && !flush_next_q) begin
      ready_q <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      flush_next_q <= 1'b0;
    end else if (under_ev) begin
      flush_next_q <= 1'b1;
    end else if (discard_load) begin
      flush_next_q <= 1'b0;
    end
  end

  // Sticky flags, set wins over read-clear
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      in_stall_sent_q  <= 1'b0;
      underrun_q       <= 1'b0;
      out_stall_sent_q <= 1'b0;
    end else begin
      in_stall_sent_q <= stall_ev ||
        (in_stall_sent_q && !clr_mask[ep2_pkg::BIT_IN_STALL_SENT]);
      underrun_q <= under_ev ||
        (underrun_q && !clr_mask[ep2_pkg::BIT_IN_UNDERRUN]);
      out_stall_sent_q <= out_stall_ev ||
        (out_stall_sent_q && !clr_mask[ep2_pkg::BIT_OUT_STALL_SENT]);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      IN_SEND_DATA   <= 1'b0;
      IN_SEND_NAK    <= 1'b0;
      IN_SEND_STALL  <= 1'b0;
      IN_SEND_ZLP    <= 1'b0;
      FIFO_FLUSH_ONE <= 1'b0;
      FIFO_WR_BLOCK  <= 1'b0;
      CPU_IRQ        <= 1'b0;
    end else begin
      IN_SEND_DATA   <= data_ev;
      IN_SEND_NAK    <= nak_ev;
      IN_SEND_STALL  <= stall_ev;
      IN_SEND_ZLP    <= under_ev;
      FIFO_FLUSH_ONE <= flush_do || discard_load;
      FIFO_WR_BLOCK  <= (ready_q || (cpu_set_ready && !flush_next_q)) &&
                        !(stall_ev || sent_ev || flush_do);
      CPU_IRQ        <= sent_ev || flush_do;
    end
  end

  in_fifo_tracker #(
    .FIFO_BYTES (FIFO_BYTES)
  ) u_tracker (
    .clk       (CORE_CLK),
    .reset_n   (RESET_N),
    .push      (cpu_set_ready),
    .pop       (sent_ev || flush_do || discard_load),
    .max_bytes (max_bytes(max_packet_q)),
    .occupancy (occupancy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Data toggles and OUT side

  assign out_end = OUT_DATA_END && !direction_q;
  assign out_stall_ev = out_end &&
    (OUT_RX_BYTES > max_bytes(max_packet_q));

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      IN_TOGGLE <= 1'b0;
    end else if (wr_go && direction_q &&
                 wbit(WRITEDATA, BYTEENABLE,
                      ep2_pkg::BIT_IN_CLEAR_TOGGLE)) begin
      IN_TOGGLE <= 1'b0;
    end else if (sent_ev) begin
      IN_TOGGLE <= !IN_TOGGLE;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      OUT_TOGGLE <= 1'b0;
    end else if (wr_go && !direction_q &&
                 wbit(WRITEDATA, BYTEENABLE,
                      ep2_pkg::BIT_OUT_CLEAR_TOGGLE)) begin
      OUT_TOGGLE <= 1'b0;
    end else if (out_end && !out_stall_ev) begin
      OUT_TOGGLE <= !OUT_TOGGLE;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      OUT_SEND_STALL <= 1'b0;
      OUT_SEND_ACK   <= 1'b0;
    end else begin
      OUT_SEND_STALL <= out_stall_ev;
      OUT_SEND_ACK   <= out_end && !out_stall_ev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_stall_answer: assert property (
    IN_TOKEN && direction_q && send_stall_q |=> IN_SEND_STALL && !ready_q)
    else $error("stall answer or ready clear missing");

  chk_stall_sent_set: assert property (
    IN_SEND_STALL |-> in_stall_sent_q)
    else $error("in stall sent not set");

  chk_ready_blocked: assert property (
    send_stall_q && !ready_q |=> !ready_q)
    else $error("ready set during stall");

  chk_flush_waits: assert property (
    flush_q && TOKEN_BUSY |=> flush_q && !FIFO_FLUSH_ONE)
    else $error("flush during busy token");

  chk_flush_done: assert property (
    flush_q && !TOKEN_BUSY && direction_q |=> !flush_q && CPU_IRQ &&
    FIFO_FLUSH_ONE && !ready_q)
    else $error("flush completion wrong");

  chk_underrun_zlp: assert property (
    IN_TOKEN && direction_q && iso_q && !send_stall_q && !ready_q
    |=> IN_SEND_ZLP && underrun_q && flush_next_q)
    else $error("underrun not handled");

  chk_sent_irq: assert property (
    IN_XFER_DONE && direction_q && ready_q |=> CPU_IRQ && !ready_q)
    else $error("sent packet not reported");

  chk_wr_block: assert property (
    FIFO_WR_BLOCK == ready_q)
    else $error("fifo write block mismatch");

  chk_out_stall: assert property (
    OUT_DATA_END && !direction_q && OUT_RX_BYTES > max_bytes(max_packet_q)
    |=> OUT_SEND_STALL && out_stall_sent_q && !OUT_SEND_ACK)
    else $error("oversize out not stalled");

  chk_bus_answer: assert property (
    (READ || WRITE) && WAITREQUEST |=> !WAITREQUEST)
    else $error("bus answer late");

  chk_rsvd_zero: assert property (
    !READDATA[31] && !READDATA[ep2_pkg::BIT_IN_CLEAR_TOGGLE])
    else $error("reserved or write-only bit read as one");

  cov_stall: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
    IN_SEND_STALL);
  cov_flush: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
    flush_q && TOKEN_BUSY ##[1:20] FIFO_FLUSH_ONE);
  cov_underrun: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
    IN_SEND_ZLP ##[1:50] FIFO_FLUSH_ONE);
  cov_sent: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
    ready_q ##[1:50] CPU_IRQ);

endmodule : usb_endpoint_in_control_status

/* test/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] BASE = 32'h0000_2001;
  logic        CORE_CLK, RESET_N, READ, WRITE;
  logic [7:0]  ADDRESS, OUT_RX_BYTES;
  logic [31:0] WRITEDATA, READDATA, q;
  logic        WAITREQUEST, IN_TOKEN, IN_XFER_DONE, TOKEN_BUSY, OUT_DATA_END;
  logic        IN_SEND_DATA, IN_SEND_NAK, IN_SEND_STALL, IN_SEND_ZLP;
  logic        OUT_SEND_STALL, OUT_SEND_ACK, FIFO_FLUSH_ONE, FIFO_WR_BLOCK;
  logic        IN_TOGGLE, OUT_TOGGLE, CPU_IRQ;
  logic [7:0]  s;
  int          err_total, num_checks;

  usb_endpoint_in_control_status dut (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N),
    .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA),
    .BYTEENABLE(4'hf), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
    .IN_TOKEN(IN_TOKEN), .IN_XFER_DONE(IN_XFER_DONE),
    .TOKEN_BUSY(TOKEN_BUSY), .OUT_DATA_END(OUT_DATA_END),
    .OUT_RX_BYTES(OUT_RX_BYTES), .IN_SEND_DATA(IN_SEND_DATA),
    .IN_SEND_NAK(IN_SEND_NAK), .IN_SEND_STALL(IN_SEND_STALL),
    .IN_SEND_ZLP(IN_SEND_ZLP), .OUT_SEND_STALL(OUT_SEND_STALL),
    .OUT_SEND_ACK(OUT_SEND_ACK), .FIFO_FLUSH_ONE(FIFO_FLUSH_ONE),
    .FIFO_WR_BLOCK(FIFO_WR_BLOCK), .IN_TOGGLE(IN_TOGGLE),
    .OUT_TOGGLE(OUT_TOGGLE), .CPU_IRQ(CPU_IRQ));

  usb_host_model host (.CORE_CLK(CORE_CLK), .IN_SEND_DATA(IN_SEND_DATA),
    .IN_SEND_NAK(IN_SEND_NAK), .IN_SEND_STALL(IN_SEND_STALL),
    .IN_SEND_ZLP(IN_SEND_ZLP), .OUT_SEND_STALL(OUT_SEND_STALL),
    .OUT_SEND_ACK(OUT_SEND_ACK), .FIFO_FLUSH_ONE(FIFO_FLUSH_ONE),
    .CPU_IRQ(CPU_IRQ), .IN_TOKEN(IN_TOKEN), .IN_XFER_DONE(IN_XFER_DONE),
    .TOKEN_BUSY(TOKEN_BUSY), .OUT_DATA_END(OUT_DATA_END),
    .OUT_RX_BYTES(OUT_RX_BYTES));

  initial begin
    CORE_CLK = 1'b0;
    forever #12.5 CORE_CLK = ~CORE_CLK;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Avalon cycle, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge CORE_CLK);
    READ <= !w;
    WRITE <= w;
    ADDRESS <= a;
    WRITEDATA <= d;
    n = 0;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (WAITREQUEST !== 1'b0 && n < 50);
    if (n >= 50) begin
      err_total++;
      $display("[ERR] waitrequest expected 0 seen 1");
      close_out();
    end else begin
      r = READDATA;
      READ <= 1'b0;
      WRITE <= 1'b0;
    end
  endtask : bus

  task automatic wr(input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, 8'h28, d, r);
  endtask : wr

  task automatic rd();
    bus(1'b0, 8'h28, 32'h0, q);
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd();
    chk("reset value", BASE, q);
    bus(1'b0, 8'h2c, 32'h0, q);
    chk("unmapped read", 32'h0, q);
    bus(1'b1, 8'h2c, 32'hffff_ffff, q);
    wr(BASE | 32'h8000_0000);
    rd();
    chk("reserved and unmapped writes", BASE, q);
    $display("test reset done");
  endtask : t_reset

  task automatic t_send();
    wr(BASE | 32'h0100_0000);
    rd();
    chk("occupancy one", 2'b11, q[25:24]);
    chk("write block", 1'b1, FIFO_WR_BLOCK);
    host.send(0, 8'h0, s);
    chk("IN data answer", 8'h80, s);
    host.send(1, 8'h0, s);
    chk("sent interrupt", 8'h01, s);
    chk("block released", 1'b0, FIFO_WR_BLOCK);
    chk("IN toggle flip", 1'b1, IN_TOGGLE);
    rd();
    chk("fifo empty", 2'b00, q[25:24]);
    wr(BASE | 32'h4000_0000);
    rd();
    chk("IN toggle clear", 1'b0, IN_TOGGLE);
    chk("clear bit reads", 1'b0, q[30]);
    $display("test send done");
  endtask : t_send

  task automatic t_stall();
    wr(BASE | 32'h0100_0000);
    wr(BASE | 32'h1000_0000);
    host.send(0, 8'h0, s);
    chk("stall answer", 8'h20, s);
    chk("stall clears ready", 1'b0, FIFO_WR_BLOCK);
    rd();
    chk("stall sent set", 1'b1, q[29]);
    rd();
    chk("stall sent cleared", 1'b0, q[29]);
    wr(BASE | 32'h1100_0000);
    rd();
    chk("ready ignored", 1'b0, FIFO_WR_BLOCK);
    wr(BASE);
    host.send(0, 8'h0, s);
    chk("stall ended", 8'h40, s);
    $display("test stall done");
  endtask : t_stall

  task automatic t_flush();
    wr(BASE | 32'h0100_0000);
    rd();
    chk("two packets", 2'b11, q[25:24]);
    host.hold_busy();
    wr(BASE | 32'h0800_0000);
    rd();
    chk("flush delayed", 1'b1, q[27]);
    host.send(2, 8'h0, s);
    chk("flush and irq", 8'h03, s);
    rd();
    chk("flush self clear", 1'b0, q[27]);
    chk("oldest discarded", 2'b10, q[25:24]);
    chk("ready cleared", 1'b0, FIFO_WR_BLOCK);
    wr(BASE | 32'h0800_0000);
    rd();
    chk("fifo drained", 2'b00, q[25:24]);
    $display("test flush done");
  endtask : t_flush

  task automatic t_iso();
    wr(BASE | 32'h0000_4000);
    host.send(0, 8'h0, s);
    chk("zero length", 8'h10, s);
    rd();
    chk("underrun set", 1'b1, q[26]);
    rd();
    chk("underrun cleared", 1'b0, q[26]);
    wr(BASE | 32'h0100_4000);
    rd();
    chk("next packet dropped", 2'b00, q[25:24]);
    chk("ready not kept", 1'b0, FIFO_WR_BLOCK);
    $display("test iso done");
  endtask : t_iso

  task automatic t_out();
    wr(32'h0000_0001);
    host.send(3, 8'd8, s);
    chk("OUT ack", 8'h04, s);
    chk("OUT toggle flip", 1'b1, OUT_TOGGLE);
    host.send(3, 8'd9, s);
    chk("OUT stall", 8'h08, s);
    rd();
    chk("OUT stall sent", 1'b1, q[22]);
    rd();
    chk("OUT stall cleared", 1'b0, q[22]);
    host.send(0, 8'h0, s);
    chk("IN in OUT mode", 8'h00, s);
    wr(32'h0080_0001);
    rd();
    chk("OUT toggle clear", 1'b0, OUT_TOGGLE);
    wr(32'h0000_0008);
    host.send(3, 8'd64, s);
    chk("64 byte ack", 8'h04, s);
    host.send(3, 8'd65, s);
    chk("65 byte stall", 8'h08, s);
    wr(BASE);
    $display("test out done");
  endtask : t_out

  initial begin
    err_total = 0;
    num_checks = 0;
    RESET_N = 1'b0;
    READ = 1'b0;
    WRITE = 1'b0;
    ADDRESS = 8'h0;
    WRITEDATA = 32'h0;
    repeat (2) @(posedge CORE_CLK);
    RESET_N <= 1'b1;
    t_reset();
    t_send();
    t_stall();
    t_flush();
    t_iso();
    t_out();
    close_out();
  end
endmodule : tb

/* test/usb_host_model.sv */
module usb_host_model (
  input  wire logic       CORE_CLK,
  input  wire logic       IN_SEND_DATA,
  input  wire logic       IN_SEND_NAK,
  input  wire logic       IN_SEND_STALL,
  input  wire logic       IN_SEND_ZLP,
  input  wire logic       OUT_SEND_STALL,
  input  wire logic       OUT_SEND_ACK,
  input  wire logic       FIFO_FLUSH_ONE,
  input  wire logic       CPU_IRQ,
  output logic            IN_TOKEN,
  output logic            IN_XFER_DONE,
  output logic            TOKEN_BUSY,
  output logic            OUT_DATA_END,
  output logic      [7:0] OUT_RX_BYTES
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    IN_TOKEN = 1'b0;
    IN_XFER_DONE = 1'b0;
    TOKEN_BUSY = 1'b0;
    OUT_DATA_END = 1'b0;
    OUT_RX_BYTES = 8'hff;
  end

  // Kind 0 IN token, 1 host ack, 2 end of busy token, 3 OUT data stage
  task automatic send(input int kind, input logic [7:0] bytes,
                      output logic [7:0] snap);
    @(posedge CORE_CLK);
    case (kind)
      0: IN_TOKEN <= 1'b1;
      1: IN_XFER_DONE <= 1'b1;
      2: TOKEN_BUSY <= 1'b0;
      default: begin
        OUT_DATA_END <= 1'b1;
        OUT_RX_BYTES <= bytes;
      end
    endcase
    @(posedge CORE_CLK);
    IN_TOKEN <= 1'b0;
    IN_XFER_DONE <= 1'b0;
    OUT_DATA_END <= 1'b0;
    OUT_RX_BYTES <= ~bytes;
    @(posedge CORE_CLK);
    snap = {IN_SEND_DATA, IN_SEND_NAK, IN_SEND_STALL, IN_SEND_ZLP,
            OUT_SEND_STALL, OUT_SEND_ACK, FIFO_FLUSH_ONE, CPU_IRQ};
  endtask : send

  task automatic hold_busy();
    @(posedge CORE_CLK);
    TOKEN_BUSY <= 1'b1;
  endtask : hold_busy
endmodule : usb_host_model
